// ### inc/fsc_pkg.sv
/*
  Package for the four-channel frequency/speed counter: timing counts,
  flag layout, measuring modes, host-side carriers and state records.
  Assumes a single 40 MHz clock shared by every file that imports it.
*/
`default_nettype none
package fsc_pkg;
  localparam int NUM_CH       = 4;
  localparam int CLK_MHZ      = 40;
  localparam longint CLK_HZ   = 64'd40_000_000;
  // Glitch rejection time on the slow 24 V inputs, in ns
  localparam int GLITCH_NS    = 100_000;
  localparam int GLITCH_CYC   = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int FCNT_W       = 12;
  localparam int PER_W        = 32;
  localparam int NUM_W        = 40;
  // Synchroniser lane layout
  localparam int SY_PULSE     = 0;
  localparam int SY_FAST      = 4;
  localparam int SY_OVL       = 5;
  localparam int SY_ACK       = 9;
  localparam int SY_SUPPLY    = 10;
  localparam int SY_PROC      = 11;
  localparam int NSYNC        = 15;
  // Flag word field positions
  localparam int FL_LOW       = 0;
  localparam int FL_HIGH      = 4;
  localparam int FL_PROC      = 8;
  localparam logic [15:0] FLAGS_RST  = 16'h0000;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [PER_W-1:0] PER_MAX = {PER_W{1'b1}};

  typedef enum logic [2:0] {
    FSC_FREQ_20  = 3'h0,   // 0.001 Hz units
    FSC_FREQ_1K  = 3'h1,   // 0.1 Hz units
    FSC_FREQ_50K = 3'h2,   // 1 Hz units
    FSC_RPM_1200 = 3'h3,   // 0.1 rev/min units
    FSC_RPM_60K  = 3'h4,   // 1 rev/min units
    FSC_RPM_65K  = 3'h5    // 1 rev/min units
  } fsc_mode_e;

  // Full-scale result per mode
  localparam logic [15:0] MAX_FREQ_20  = 16'h4E20;  // 20000
  localparam logic [15:0] MAX_FREQ_1K  = 16'h2710;  // 10000
  localparam logic [15:0] MAX_FREQ_50K = 16'hC350;  // 50000
  localparam logic [15:0] MAX_RPM_1200 = 16'h2EE0;  // 12000
  localparam logic [15:0] MAX_RPM_60K  = 16'hEA60;  // 60000
  localparam logic [15:0] MAX_RPM_65K  = 16'hFFF0;  // 65520
  // Numerators: result = scale * CLK_HZ / period_cycles
  localparam logic [NUM_W-1:0] NUM_F20  = NUM_W'(64'd1000 * CLK_HZ);
  localparam logic [NUM_W-1:0] NUM_F1K  = NUM_W'(64'd10 * CLK_HZ);
  localparam logic [NUM_W-1:0] NUM_F50K = NUM_W'(CLK_HZ);
  localparam logic [NUM_W-1:0] NUM_R12  = NUM_W'(64'd600 * CLK_HZ);
  localparam logic [NUM_W-1:0] NUM_R60  = NUM_W'(64'd60 * CLK_HZ);

  typedef struct packed {
    logic [NUM_CH-1:0][2:0]  mode;     // fsc_mode_e code per channel
    logic [NUM_CH-1:0][15:0] upper;
    logic [NUM_CH-1:0][15:0] lower;
    logic                    ch1_fast; // Channel 1 counts the 5 V input
  } fsc_cfg_s;

  typedef struct packed {
    logic [15:0]             flags;    // limit_flag_word
    logic [NUM_CH-1:0][15:0] result;   // channel1_result .. channel4_result
  } fsc_regs_s;

  typedef enum logic [0:0] {
    FSC_SV_IDLE = 1'b0,
    FSC_SV_WAIT = 1'b1
  } fsc_sv_e;

  typedef enum logic [0:0] {
    FSC_DV_IDLE = 1'b0,
    FSC_DV_RUN  = 1'b1
  } fsc_dv_e;

  typedef struct packed {
    logic [NSYNC-1:0]              s1, s2, s3, lvl;
    logic [NUM_CH-1:0]             filt, prev, seen, pend;
    logic [NUM_CH-1:0][FCNT_W-1:0] fcnt;
    logic [NUM_CH-1:0][PER_W-1:0]  per_cnt, per;
    logic [1:0]                    rr, cur;
    fsc_sv_e                       sv;
    logic                          dstart;
    fsc_regs_s                     regs;
    logic [NUM_CH-1:0]             cmd, trip, drv;
    logic                          ind, sc;
  } fsc_top_st_s;

  typedef struct packed {
    fsc_dv_e          st;
    logic [5:0]       step;
    logic [NUM_W-1:0] q;
    logic [PER_W:0]   rem;
    logic [PER_W-1:0] den;
    logic             done;
  } fsc_div_st_s;
endpackage
`default_nettype wire

// ### logic/fsc_div.sv
/*
  Sequential restoring divider, one quotient bit per clock.
  Assumes the caller holds off a new start until done has pulsed and
  never offers a zero divisor.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_div
  import fsc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Request
  input  wire logic             start,
  input  wire logic [NUM_W-1:0] num,
  input  wire logic [PER_W-1:0] den,
  // Answer
  output logic                  done,
  output logic [NUM_W-1:0]      quo
);
  fsc_div_st_s st_ff;
  fsc_div_st_s nxt_st;
  logic [PER_W:0] trial;

  // One shift-subtract step per cycle; small area traded for latency
  always_comb begin
    nxt_st = st_ff;
    trial = '0;
    nxt_st.done = 1'b0;
    unique case (st_ff.st)
      FSC_DV_IDLE: begin
        if (start) begin
          nxt_st.st = FSC_DV_RUN;
          nxt_st.q = num;
          nxt_st.rem = '0;
          nxt_st.den = den;
          nxt_st.step = 6'(NUM_W);
        end
      end
      FSC_DV_RUN: begin
        trial = {st_ff.rem[PER_W-1:0], st_ff.q[NUM_W-1]};
        nxt_st.q = {st_ff.q[NUM_W-2:0], 1'b0};
        if (trial >= {1'b0, st_ff.den}) begin
          nxt_st.rem = trial - {1'b0, st_ff.den};
          nxt_st.q[0] = 1'b1;
        end else begin
          nxt_st.rem = trial;
        end
        nxt_st.step = st_ff.step - 6'h01;
        if (st_ff.step == 6'h01) begin
          nxt_st.st = FSC_DV_IDLE;
          nxt_st.done = 1'b1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;
  assign quo  = st_ff.q;
endmodule // fsc_div
`default_nettype wire

// ### logic/fsc_counter.sv
/*
  Four-channel frequency/speed counter with limit outputs, overload
  switch-off and five read-only host registers.
  Assumes pins arrive asynchronously and the host configuration is a
  stable level set before results are relied upon.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_counter
  import fsc_pkg::*;
#(
  parameter int FILT_CYC = GLITCH_CYC
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Host configuration
  input  wire fsc_cfg_s          cfg,
  // Counter pins
  input  wire logic [NUM_CH-1:0] pulse_in,
  input  wire logic              first_pulse_input,
  // Output stage pins
  input  wire logic [NUM_CH-1:0] overload_in,
  input  wire logic              supply_ok,
  input  wire logic              ack_in,
  // Free process inputs
  input  wire logic [NUM_CH-1:0] proc_in,
  // Host registers
  output fsc_regs_s              regs,
  // Output stage and indicators
  output logic [NUM_CH-1:0]      out_drive,
  output logic                   overload_ind,
  output logic                   short_grp
);
  if (FILT_CYC < 1 || FILT_CYC >= (1 << FCNT_W)) begin : g_bad_filt
    $error("FILT_CYC out of range for the filter counter");
  end

  // The service pointer is two bits wide, so exactly four channels
  if (NUM_CH != 4) begin : g_bad_ch
    $error("channel count must be four for the service pointer");
  end

  // A full divider round must end before the fastest input can deliver
  // its next period, or the fast channel would keep losing results
  localparam int ROUND_CYC = NUM_CH * (NUM_W + 2);
  if (ROUND_CYC >= int'(CLK_HZ / 64'(MAX_FREQ_50K))) begin : g_slow_div
    $error("shared divider too slow for the fastest input");
  end

  fsc_top_st_s       st_ff;
  fsc_top_st_s       nxt_st;
  logic              div_done;
  logic [NUM_W-1:0]  div_quo;
  logic [NUM_W-1:0]  div_num;
  logic [PER_W-1:0]  div_den;

  // Numerator for a mode; unknown codes give zero so the result stays 0
  function automatic logic [NUM_W-1:0] mode_num(input logic [2:0] m);
    unique case (m)
      FSC_FREQ_20:  mode_num = NUM_F20;
      FSC_FREQ_1K:  mode_num = NUM_F1K;
      FSC_FREQ_50K: mode_num = NUM_F50K;
      FSC_RPM_1200: mode_num = NUM_R12;
      FSC_RPM_60K,
      FSC_RPM_65K:  mode_num = NUM_R60;
      default:      mode_num = '0;
    endcase
  endfunction

  // Full-scale clamp of a mode
  function automatic logic [15:0] mode_max(input logic [2:0] m);
    unique case (m)
      FSC_FREQ_20:  mode_max = MAX_FREQ_20;
      FSC_FREQ_1K:  mode_max = MAX_FREQ_1K;
      FSC_FREQ_50K: mode_max = MAX_FREQ_50K;
      FSC_RPM_1200: mode_max = MAX_RPM_1200;
      FSC_RPM_60K:  mode_max = MAX_RPM_60K;
      FSC_RPM_65K:  mode_max = MAX_RPM_65K;
      default:      mode_max = RESULT_RST;
    endcase
  endfunction

  // Shared divider serves the channels one at a time
  assign div_num = mode_num(cfg.mode[st_ff.cur]);
  assign div_den = st_ff.per[st_ff.cur];

  fsc_div u_div (
    .clk   (clk),
    .reset (reset),
    .start (st_ff.dstart),
    .num   (div_num),
    .den   (div_den),
    .done  (div_done),
    .quo   (div_quo)
  );

  always_comb begin
    logic [NUM_CH-1:0] edge_rise;
    logic [NUM_CH-1:0] cnt_src;
    logic [2:0]        pick;
    logic [15:0]       lim;
    logic [1:0]        idx;
    nxt_st = st_ff;
    edge_rise = '0;
    cnt_src = '0;
    pick = '0;
    lim = '0;
    idx = '0;

    nxt_st.s1 = {proc_in,           // Lanes 14..11
                 supply_ok,         // Lane 10
                 ack_in,            // Lane 9
                 overload_in,       // Lanes 8..5
                 first_pulse_input, // Lane 4, fast path
                 pulse_in};         // Lanes 3..0
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < NSYNC; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.lvl[i] = st_ff.s3[i];
      end
    end

    // Glitch rejection on 24 V inputs; pulses shorter than the filter are lost
    for (int i = 0; i < NUM_CH; i++) begin
      if (st_ff.lvl[SY_PULSE + i] == st_ff.filt[i]) begin
        nxt_st.fcnt[i] = '0;
      end else if (st_ff.fcnt[i] == FCNT_W'(FILT_CYC - 1)) begin
        nxt_st.fcnt[i] = '0;
        nxt_st.filt[i] = st_ff.lvl[SY_PULSE + i];
      end else begin
        nxt_st.fcnt[i] = st_ff.fcnt[i] + FCNT_W'(1);
      end
    end

    // Fast 5 V path bypasses the filter
    cnt_src = st_ff.filt;
    if (cfg.ch1_fast) begin
      cnt_src[0] = st_ff.lvl[SY_FAST];
    end
    nxt_st.prev = cnt_src;
    edge_rise = cnt_src & ~st_ff.prev;

    // Divider service: start one pending channel, then wait for its quotient
    nxt_st.dstart = 1'b0;
    unique case (st_ff.sv)
      FSC_SV_IDLE: begin
        for (int k = NUM_CH - 1; k >= 0; k--) begin
          idx = st_ff.rr + 2'(k);
          if (st_ff.pend[idx]) begin
            pick = {1'b1, idx};
          end
        end
        if (pick[2]) begin
          nxt_st.cur = pick[1:0];
          nxt_st.rr = pick[1:0] + 2'h1;
          nxt_st.pend[pick[1:0]] = 1'b0;
          nxt_st.dstart = 1'b1;
          nxt_st.sv = FSC_SV_WAIT;
        end
      end
      FSC_SV_WAIT: begin
        if (div_done) begin
          // Clamp at the mode's full scale
          lim = mode_max(cfg.mode[st_ff.cur]);
          if (div_quo > {{(NUM_W-16){1'b0}}, lim}) begin
            nxt_st.regs.result[st_ff.cur] = lim;
          end else begin
            nxt_st.regs.result[st_ff.cur] = div_quo[15:0];
          end
          nxt_st.sv = FSC_SV_IDLE;
        end
      end
    endcase

    // Per-channel period measurement, independent of the others
    for (int i = 0; i < NUM_CH; i++) begin
      if (st_ff.per_cnt[i] != PER_MAX) begin
        nxt_st.per_cnt[i] = st_ff.per_cnt[i] + PER_W'(1);
      end else begin
        // Stopped input: report zero rather than a stale value
        nxt_st.seen[i] = 1'b0;
        nxt_st.regs.result[i] = RESULT_RST;
      end
      if (edge_rise[i]) begin
        if (st_ff.seen[i] && st_ff.per_cnt[i] != PER_MAX) begin
          // A new period overwrites one not yet divided; latest wins
          nxt_st.per[i] = st_ff.per_cnt[i];
          nxt_st.pend[i] = 1'b1;
        end
        nxt_st.per_cnt[i] = PER_W'(1);
        nxt_st.seen[i] = 1'b1;
      end
      // Invalid mode code gives no result
      if (mode_max(cfg.mode[i]) == RESULT_RST) begin
        nxt_st.regs.result[i] = RESULT_RST;
      end
    end
    // No hold on the period: the divider copies its operands at start, so a
    // period landing mid-division is kept and served on the next round

    // Limit flags from the stored results
    for (int i = 0; i < NUM_CH; i++) begin
      nxt_st.regs.flags[FL_LOW + i] = st_ff.regs.result[i] <= cfg.lower[i];
      nxt_st.regs.flags[FL_HIGH + i] = st_ff.regs.result[i] >= cfg.upper[i];
    end
    nxt_st.regs.flags[FL_PROC +: NUM_CH] = st_ff.lvl[SY_PROC +: NUM_CH];
    nxt_st.regs.flags[15:12] = 4'h0;

    // Output command follows the upper-limit flag, kept through a trip
    nxt_st.cmd = st_ff.regs.flags[FL_HIGH +: NUM_CH];

    // Acknowledge releases lockout only once overload is gone
    if (st_ff.lvl[SY_ACK]) begin
      nxt_st.trip = st_ff.trip & st_ff.lvl[SY_OVL +: NUM_CH];
      nxt_st.ind = 1'b0;
      nxt_st.sc = 1'b0;
    end
    // Overload trips the output; set wins over acknowledge
    if (|st_ff.lvl[SY_OVL +: NUM_CH]) begin
      nxt_st.trip = nxt_st.trip | st_ff.lvl[SY_OVL +: NUM_CH];
      nxt_st.ind = 1'b1;
      nxt_st.sc = 1'b1;
    end

    // Drive only while supply present and not tripped
    nxt_st.drv = st_ff.cmd & ~st_ff.trip & {NUM_CH{st_ff.lvl[SY_SUPPLY]}};
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Five read-only words; results in channel order
  assign regs         = st_ff.regs;
  assign out_drive    = st_ff.drv;
  assign overload_ind = st_ff.ind;
  assign short_grp    = st_ff.sc;
endmodule // fsc_counter
`default_nettype wire

// ### testbench/fsc_counter_props.sv
/*
  Port-level checker for the frequency/speed counter, bound to its top.
  Assumes the three-flop pin synchronisers described for the block.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_counter_chk
  import fsc_pkg::*;
#(
  parameter int FILT_CYC = GLITCH_CYC
)(
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset,
  // Watched inputs
  input wire fsc_cfg_s          cfg,
  input wire logic [NUM_CH-1:0] overload_in,
  input wire logic              supply_ok,
  input wire logic              ack_in,
  // Watched outputs
  input wire fsc_regs_s         regs,
  input wire logic [NUM_CH-1:0] out_drive,
  input wire logic              overload_ind,
  input wire logic              short_grp
);
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Group flags and drive gating; windows allow for the pin synchronisers
  a_top_bits_zero: assert property (regs.flags[15:12] == 4'h0) // spare bits
    else $error("unused flag bits not zero");
  a_supply_gate: assert property (!supply_ok [*8] |-> out_drive == 4'h0) // no supply
    else $error("output driven without supply");
  a_ind_set: assert property ((|overload_in) [*7] |-> overload_ind && short_grp) // group
    else $error("overload not indicated");
  a_ind_sticky: assert property (!ack_in [*7] ##0 overload_ind |=> overload_ind) // latched
    else $error("indication dropped without acknowledge");
  a_ack_clear: assert property ((ack_in && overload_in == 4'h0) [*7] |-> // acknowledge
    !overload_ind && !short_grp)
    else $error("acknowledge did not clear indication");
  a_drive_follow: assert property ((out_drive & ~$past(regs.flags[7:4], 2)) == 4'h0) // cmd
    else $error("output on without upper-limit flag");

  // Per-channel switch-off and limit flags
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    a_trip_off: assert property (overload_in[i] [*8] |-> !out_drive[i]) // switch-off
      else $error("output stays on under overload");
    a_flag_limits: assert property (!$past(reset) |-> // limit flags
      regs.flags[FL_LOW+i] == ($past(regs.result[i]) <= $past(cfg.lower[i])) &&
      regs.flags[FL_HIGH+i] == ($past(regs.result[i]) >= $past(cfg.upper[i])))
      else $error("limit flag disagrees with result");
  end
endmodule // fsc_counter_chk

bind fsc_counter fsc_counter_chk #(.FILT_CYC(FILT_CYC)) u_fsc_counter_chk (
  .clk(clk), .reset(reset), .cfg(cfg), .overload_in(overload_in), .supply_ok(supply_ok),
  .ack_in(ack_in), .regs(regs), .out_drive(out_drive), .overload_ind(overload_ind),
  .short_grp(short_grp));
`default_nettype wire

// ### testbench/fsc_pulse_src.sv
/*
  Field-side pulse source: a square wave per slow pin, narrow pulses on
  the fast pin. Assumes periods are held steady for whole measurements.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_pulse_src
  import fsc_pkg::*;
(
  // Clock
  input  wire logic                    clk,
  // Periods in cycles, zero holds a pin low
  input  wire logic [NUM_CH-1:0][15:0] per,
  input  wire logic [15:0]             per_fast,
  input  wire logic [15:0]             hi_fast,
  // Pins
  output logic      [NUM_CH-1:0]       pulse,
  output logic                         fast
);
  int unsigned cnt = 0;

  // Pins start low so no edge is invented at time zero
  initial begin
    pulse = '0;
    fast = 1'b0;
  end

  // Levels change on the falling edge, clear of the sampling edge
  always @(negedge clk) begin
    cnt <= cnt + 1;
    // half duty keeps each level far beyond the filter
    for (int i = 0; i < NUM_CH; i++) begin
      pulse[i] <= (per[i] != 0) && ((cnt % per[i]) < per[i] / 2);
    end
    // narrow pulses that only the unfiltered pin can follow
    fast <= (per_fast != 0) && ((cnt % per_fast) < hi_fast);
  end
endmodule // fsc_pulse_src
`default_nettype wire

// ### testbench/fsc_counter_test.sv
/*
  Self-checking bench for the counter: a table of measuring setups, then
  overload, supply, fast-pin and reset cases. Assumes a shortened filter.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_counter_test
  import fsc_pkg::*;
();
  localparam int FILT  = 20;
  localparam int LIMIT = 30000;
  typedef struct {
    logic [3:0][2:0]  mode;
    logic [3:0][15:0] per, lower, upper;
    logic [3:0]       proc;
  } fsc_row_s;

  logic                    clk = 1'b0;
  logic                    reset = 1'b1;
  fsc_cfg_s                cfg = '0;
  logic [NUM_CH-1:0]       pulse_in, out_drive, overload_in = '0, proc_in = '0;
  logic                    first_pulse_input, supply_ok = 1'b1, ack_in = 1'b0;
  logic                    overload_ind, short_grp;
  fsc_regs_s               regs;
  logic [NUM_CH-1:0][15:0] per = '0;
  logic [15:0]             per_fast = '0, hi_fast = '0, fl, ex;
  int                      n_mismatch = 0, samples_checked = 0, cyc = 0;
  fsc_row_s                rows [2];
  // Overload steps: pins in, then drive and indication expected
  logic [3:0]              ovl_t [5] = '{4'h2, 4'h2, 4'h0, 4'h0, 4'h0};
  logic                    ack_t [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic                    sup_t [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [3:0]              drv_t [5] = '{4'h1, 4'h1, 4'h1, 4'h3, 4'h0};
  logic                    ind_t [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  fsc_counter #(.FILT_CYC(FILT)) u_fsc_counter (
    .clk(clk), .reset(reset), .cfg(cfg), .pulse_in(pulse_in),
    .first_pulse_input(first_pulse_input), .overload_in(overload_in),
    .supply_ok(supply_ok), .ack_in(ack_in), .proc_in(proc_in), .regs(regs),
    .out_drive(out_drive), .overload_ind(overload_ind), .short_grp(short_grp));
  fsc_pulse_src u_fsc_pulse_src (.clk(clk), .per(per), .per_fast(per_fast),
    .hi_fast(hi_fast), .pulse(pulse_in), .fast(first_pulse_input));

  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  // Result per mode, clamped at the mode's full scale; spare codes read 0
  function automatic logic [15:0] exp_res(input logic [2:0] m, input logic [15:0] p);
    logic [NUM_W-1:0] num [6];
    logic [15:0]      mx [6];
    logic [NUM_W-1:0] q;
    num = '{NUM_F20, NUM_F1K, NUM_F50K, NUM_R12, NUM_R60, NUM_R60};
    mx = '{MAX_FREQ_20, MAX_FREQ_1K, MAX_FREQ_50K,
           MAX_RPM_1200, MAX_RPM_60K, MAX_RPM_65K};
    if (m > 3'h5) begin
      return 16'h0000;
    end
    q = num[m] / p;
    return (q > NUM_W'(mx[m])) ? mx[m] : q[15:0];
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short; the budget is about twice the planned run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    // Limits sit on the boundaries so off-by-one compares show up
    rows[0] = '{{3'h3, 3'h2, 3'h1, 3'h0}, {16'h07D0, 16'h0640, 16'h03E8, 16'h0320},
                {16'h2EDF, 16'h0000, 16'h0000, 16'h4E20},
                {16'hFFFF, 16'h61A9, 16'h2710, 16'hFFFF}, 4'hA};
    rows[1] = '{{3'h6, 3'h2, 3'h5, 3'h4}, {16'h0320, 16'h03E8, 16'h0640, 16'h07D0},
                {16'h0000, 16'h9C40, 16'h0000, 16'h0000},
                {16'h0001, 16'hFFFF, 16'hFFF0, 16'hEA60}, 4'h5};
    // Registers read zero under reset; once released, zero limits raise the flags
    wait_cyc(16);
    check({15'h0, regs !== '0}, 16'h0000); // registers clear
    reset = 1'b0;
    wait_cyc(2);
    check(regs.flags, 16'h00FF); // zero result at zero limits
    check(16'(out_drive), 16'h0000); // outputs off
    $display("power-up test done");
    // Table of setups; three new periods pass before looking
    foreach (rows[r]) begin
      // Host sets modes and limits first
      cfg.mode = rows[r].mode;
      cfg.lower = rows[r].lower;
      cfg.upper = rows[r].upper;
      per = rows[r].per;
      proc_in = rows[r].proc;
      wait_cyc(6500);
      fl = {4'h0, rows[r].proc, 8'h00};
      for (int i = 0; i < NUM_CH; i++) begin
        ex = exp_res(rows[r].mode[i], rows[r].per[i]);
        check(regs.result[i], ex); // result
        fl[FL_LOW+i] = ex <= rows[r].lower[i];
        fl[FL_HIGH+i] = ex >= rows[r].upper[i];
      end
      check(regs.flags, fl); // flag word
      check(16'(out_drive), 16'(fl[7:4])); // limit outputs
      $display("setup %0d test done", r);
    end
    // Overload held through acknowledge, then released, then supply lost
    for (int s = 0; s < 5; s++) begin
      overload_in = ovl_t[s];
      ack_in = ack_t[s];
      supply_ok = sup_t[s];
      wait_cyc(12);
      check(16'(out_drive), 16'(drv_t[s])); // drive
      check({14'h0, overload_ind, short_grp}, {14'h0, ind_t[s], ind_t[s]}); // ind
    end
    $display("overload test done");
    // Narrow pulses on the fast pin while the slow pin rests
    supply_ok = 1'b1;
    overload_in = 4'h4;
    cfg.ch1_fast = 1'b1;
    cfg.mode[0] = 3'h2;
    per[0] = 16'h0000;
    per_fast = 16'h03E8;
    hi_fast = 16'h000A;
    wait_cyc(3500);
    check(regs.result[0], exp_res(3'h2, 16'h03E8)); // fast pin
    check({15'h0, overload_ind}, 16'h0001); // indication set
    $display("fast pin test done");
    // Reset in mid-run clears results and latched indication
    reset = 1'b1;
    wait_cyc(2);
    check({15'h0, regs !== '0}, 16'h0000); // registers clear
    check({10'h000, out_drive, overload_ind, short_grp}, 16'h0000); // off
    reset = 1'b0;
    $display("reset test done");
    print_verdict();
  end
endmodule // fsc_counter_test
`default_nettype wire
